// ==== adc_repeat_sweep_sequencer.sv ====
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module adc_repeat_sweep_sequencer (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [7:0]  i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   // Triggers
   input  wire logic        i_cmp_flag,
   input  wire logic        i_ext_trig_b,
   // Analog front end
   input  wire logic [9:0]  i_ain,
   output logic [3:0]       o_chan_sel,
   output logic             o_analog_on,
   output logic             o_ref_en,
   // Interrupt request pulse
   output logic             o_irq
);
   import adc_seq_pkg::*;

   logic        run_q, run_d;
   logic [2:0]  mode_q, mode_d;
   logic [1:0]  trig_q, trig_d;
   insel_s      insel_q, insel_d;
   logic        stby_q, stby_d, ext_q, ext_d, res10_q, res10_d;
   logic        ref_q, ref_d;
   seq_state_e  state_q, state_d;
   logic [1:0]  pos_q, pos_d;
   logic [2:0]  ring_q, ring_d;
   logic [3:0]  chan_q, chan_d;
   logic        irq_q, irq_d, start_q, start_d;
   logic        cmp_q, pin_q;
   logic [9:0]  slot_q [8];
   logic        wr_q;
   logic [7:0]  wa_q;
   logic [31:0] rd_q, rd_d;
   conv_res_s   eng;
   logic        acc, ctl0_wr, trig_ev, eng_ok, last;
   logic [3:0]  an_single;
   logic [2:0]  wslot;
   logic [1:0]  npos;

   adc_sar_engine #(.CYCLES(CONV_CYCLES)) u_eng (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_start (start_q),
      .i_abort (state_q == ST_CONV && !run_q),
      .i_res10 (res10_q),
      .i_ain   (i_ain),
      .o_res   (eng)
   );

   function automatic logic [3:0] sweep_an(input logic [1:0] grp,
                                           input logic [1:0] p);
      // Group zero sweeps inputs 0-1, others start at input 8
      sweep_an = (grp == 2'h0) ? {3'h0, p[0]} : {2'h2, p};
   endfunction

   // Bus
   assign acc     = i_hsel && i_htrans[1] && i_hready;
   assign ctl0_wr = wr_q && wa_q == OFS_CTRL0;

   always_comb begin
      rd_d = 32'h0;
      if (acc && !i_hwrite) begin
         unique case (i_haddr)
            OFS_CTRL0: begin
               rd_d[CTRL0_RUN_BIT]  = run_q;
               rd_d[CTRL0_BUSY_BIT] = state_q == ST_CONV;
            end
            OFS_CTRL1: begin
               rd_d[CTRL1_STBY_BIT] = stby_q;
               rd_d[CTRL1_EXT_BIT]  = ext_q;
               rd_d[CTRL1_RES_BIT]  = res10_q;
            end
            OFS_MODE:   rd_d[MODE_TRIG_LSB+1:0] = {trig_q, 1'b0, mode_q};
            OFS_INSEL:  rd_d[5:0] = insel_q;
            OFS_REFCTL: rd_d[REF_EN_BIT] = ref_q;
            default: begin
               if (i_haddr[7:5] == OFS_RESULT[7:5] && i_haddr[1:0] == 2'h0)
                  rd_d[9:0] = slot_q[i_haddr[4:2]];
            end
         endcase
      end
   end

   // Sequencer
   always_comb begin
      // Edge-qualified hardware starts
      unique case (trig_q)
         TRG_SW:  trig_ev = 1'b1;
         TRG_TMR: trig_ev = i_cmp_flag && !cmp_q;
         TRG_EXT: trig_ev = !i_ext_trig_b && pin_q;
         default: trig_ev = 1'b0;
      endcase
      // Input choice from channel and group or reference
      if (ext_q)
         an_single = AN_REF;
      else if (insel_q.group == 2'h0)
         an_single = {1'b0, insel_q.chan};
      else
         an_single = {2'h2, insel_q.chan[1:0]};
      last = insel_q.sweep4 && insel_q.group != 2'h0;
      npos = (pos_q == {last, 1'b1}) ? 2'h0 : pos_q + 2'h1;
      // Result slot per mode
      if (mode_q == MODE_SSWEEP || mode_q == MODE_RSWEEP)
         wslot = {1'b0, pos_q};
      else if (mode_q == MODE_REP1)
         wslot = ring_q;
      else if (chan_q[3])
         wslot = {1'b0, chan_q[1:0]};
      else
         wslot = chan_q[2:0];
      eng_ok = eng.done && run_q;

      state_d = state_q;
      run_d   = run_q;
      pos_d   = pos_q;
      ring_d  = ring_q;
      chan_d  = chan_q;
      irq_d   = 1'b0;
      start_d = 1'b0;
      unique case (state_q)
         ST_IDLE: begin
            pos_d  = 2'h0;
            ring_d = 3'h0;
            if (run_q)
               state_d = ST_ARM;
         end
         ST_ARM: begin
            // Waits for the trigger once armed
            if (!run_q) begin
               state_d = ST_IDLE;
            end else if (trig_ev) begin
               state_d = ST_CONV;
               start_d = 1'b1;
               chan_d  = (mode_q[2]) ? sweep_an(insel_q.group, pos_q)
                                     : an_single;
            end
         end
         ST_CONV: begin
            if (!run_q) begin
               state_d = ST_IDLE; // Abort, no request
            end else if (eng_ok) begin
               start_d = 1'b1;
               unique case (mode_q)
                  MODE_REP0: ; // Endless, silent
                  MODE_REP1: begin
                     ring_d = ring_q + 3'h1;
                     irq_d  = ring_q == 3'h7;
                  end
                  MODE_SSWEEP: begin
                     pos_d = npos;
                     if (npos == 2'h0) begin
                        irq_d   = 1'b1;
                        run_d   = 1'b0;
                        start_d = 1'b0;
                        state_d = ST_IDLE;
                     end
                  end
                  MODE_RSWEEP: begin
                     pos_d = npos;
                     irq_d = npos == 2'h0;
                  end
                  default: begin
                     irq_d   = 1'b1;
                     start_d = 1'b0;
                     state_d = ST_ARM;
                     if (trig_q == TRG_SW) begin
                        run_d   = 1'b0;
                        state_d = ST_IDLE;
                     end
                  end
               endcase
               if (mode_q[2])
                  chan_d = sweep_an(insel_q.group, pos_d);
            end
         end
         default: state_d = ST_IDLE;
      endcase
      // Software write to run bit wins over hardware clear
      if (ctl0_wr)
         run_d = i_hwdata[CTRL0_RUN_BIT];
   end

   always_comb begin
      mode_d  = mode_q;
      trig_d  = trig_q;
      insel_d = insel_q;
      stby_d  = stby_q;
      ext_d   = ext_q;
      res10_d = res10_q;
      ref_d   = ref_q;
      if (wr_q) begin
         unique case (wa_q)
            OFS_MODE: begin
               mode_d = i_hwdata[2:0];
               trig_d = i_hwdata[MODE_TRIG_LSB+1:MODE_TRIG_LSB];
            end
            OFS_INSEL:  insel_d = i_hwdata[5:0];
            OFS_CTRL1: begin
               stby_d  = i_hwdata[CTRL1_STBY_BIT];
               ext_d   = i_hwdata[CTRL1_EXT_BIT];
               res10_d = i_hwdata[CTRL1_RES_BIT];
            end
            OFS_REFCTL: ref_d = i_hwdata[REF_EN_BIT];
            default: ; // Result slots ignore writes
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         run_q   <= 1'b0;
         mode_q  <= RST_MODE;
         trig_q  <= RST_TRIG;
         insel_q <= RST_INSEL;
         stby_q  <= 1'b0;
         ext_q   <= 1'b0;
         res10_q <= 1'b0;
         ref_q   <= 1'b0;
         state_q <= ST_IDLE;
         pos_q   <= 2'h0;
         ring_q  <= 3'h0;
         chan_q  <= 4'h0;
         irq_q   <= 1'b0;
         start_q <= 1'b0;
         cmp_q   <= 1'b0;
         pin_q   <= 1'b1;
         wr_q    <= 1'b0;
         wa_q    <= 8'h00;
         rd_q    <= 32'h0;
      end else begin
         run_q   <= run_d;
         mode_q  <= mode_d;
         trig_q  <= trig_d;
         insel_q <= insel_d;
         stby_q  <= stby_d; // Drives analog power gate
         ext_q   <= ext_d;
         res10_q <= res10_d;
         ref_q   <= ref_d;
         state_q <= state_d;
         pos_q   <= pos_d;
         ring_q  <= ring_d;
         chan_q  <= chan_d;
         irq_q   <= irq_d;
         start_q <= start_d;
         cmp_q   <= i_cmp_flag;
         pin_q   <= i_ext_trig_b;
         wr_q    <= acc && i_hwrite;
         wa_q    <= i_haddr;
         rd_q    <= rd_d;
      end
   end

   // Result storage; only the engine writes it
   always_ff @(posedge i_clk) begin
      if (state_q == ST_CONV && eng_ok)
         slot_q[wslot] <= eng.data;
   end

   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;
   assign o_hrdata    = rd_q;
   assign o_chan_sel  = chan_q;
   assign o_analog_on = stby_q;
   assign o_ref_en    = ref_q;
   assign o_irq       = irq_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   logic conv_done;
   assign conv_done = state_q == ST_CONV && eng_ok;

   AST_REP0_SILENT: assert property (
      conv_done && mode_q == MODE_REP0 |=> !o_irq)
      else $error("repeat mode 0 raised an interrupt");
   AST_REP0_AGAIN: assert property (
      conv_done && mode_q == MODE_REP0 |=> start_q ##1 !start_q)
      else $error("repeat mode 0 did not restart");
   AST_REP1_SLOT7: assert property (
      conv_done && mode_q == MODE_REP1 |=> o_irq == ($past(ring_q) == 3'h7))
      else $error("repeat mode 1 interrupt not tied to slot 7");
   AST_REP1_RING: assert property (
      conv_done && mode_q == MODE_REP1 |=> ring_q == $past(ring_q) + 3'h1)
      else $error("repeat mode 1 slot did not advance");
   AST_SSWEEP_END: assert property (
      conv_done && mode_q == MODE_SSWEEP && npos == 2'h0 && !ctl0_wr
      |=> !run_q && o_irq ##1 state_q == ST_IDLE)
      else $error("single sweep did not stop with interrupt");
   AST_RSWEEP_IRQ: assert property (
      conv_done && mode_q == MODE_RSWEEP && npos == 2'h0 && !ctl0_wr
      |=> o_irq && run_q && start_q)
      else $error("repeat sweep did not interrupt and continue");
   AST_ABORT: assert property (
      state_q == ST_CONV && !run_q |=> state_q == ST_IDLE && !o_irq)
      else $error("abort raised interrupt or kept running");
   AST_ARM_WAIT: assert property (
      state_q == ST_ARM && !trig_ev |=> !start_q)
      else $error("conversion started without trigger");
   AST_TMR_EDGE: assert property (
      state_q == ST_ARM && run_q && trig_q == TRG_TMR && $rose(i_cmp_flag)
      |=> start_q && state_q == ST_CONV)
      else $error("timer flag edge did not start conversion");
   AST_RUN_HOLD: assert property (
      run_q && !ctl0_wr && (mode_q == MODE_REP0 || mode_q == MODE_REP1
      || mode_q == MODE_RSWEEP) |=> run_q)
      else $error("repeat mode stopped without software");
   AST_SLOT_RO: assert property (
      wr_q && wa_q == OFS_RESULT && !conv_done |=> $stable(slot_q[0]))
      else $error("bus write changed a result slot");

   COV_REP1_WRAP: cover property (conv_done && mode_q == MODE_REP1
                                  && ring_q == 3'h7);
   COV_SSWEEP4: cover property (conv_done && mode_q == MODE_SSWEEP
                                && pos_q == 2'h3);
   COV_ABORT: cover property (state_q == ST_CONV && !run_q);

endmodule // adc_repeat_sweep_sequencer

// ==== adc_seq_pkg.sv ====
// Functional notes
// - Repeat mode 0 converts one input endlessly
// - Repeat mode 0 never raises interrupt
// - One-shot and repeat mode 0 results land in fixed slots
// - Resolution selectable, 8 or 10 bits
// - Software, timer or pin trigger starts
// - Repeat mode 1 rotates results through slots 0-7
// - Repeat mode 1 interrupts on slot 7 write
// - Repeat modes stop only on run clear
// - Sweep groups: 0-1, 8-9, 8-11
// - Single sweep ends: clears run, interrupts
// - Sweep results in fixed slots 0-3
// - Repeat sweep interrupts per sweep, continues
// - Run cleared mid-conversion aborts, no interrupt
// - Standby bit zero shuts analog current
// - Channel plus group, or extension bit
// - Trigger field: 00 sw, 10 timer, 11 pin
// - Timer flag rising edge starts conversion
package adc_seq_pkg;

   localparam int unsigned CONV_CYCLES = 40;

   localparam logic [7:0] OFS_CTRL0  = 8'h00;
   localparam logic [7:0] OFS_CTRL1  = 8'h04;
   localparam logic [7:0] OFS_MODE   = 8'h08;
   localparam logic [7:0] OFS_INSEL  = 8'h0c;
   localparam logic [7:0] OFS_REFCTL = 8'h10;
   localparam logic [7:0] OFS_RESULT = 8'h20;

   localparam int unsigned CTRL0_RUN_BIT  = 0;
   localparam int unsigned CTRL0_BUSY_BIT = 1;
   localparam int unsigned CTRL1_STBY_BIT = 0;
   localparam int unsigned CTRL1_EXT_BIT  = 1;
   localparam int unsigned CTRL1_RES_BIT  = 2;
   localparam int unsigned MODE_TRIG_LSB  = 4;
   localparam int unsigned REF_EN_BIT     = 0;

   localparam logic [2:0] MODE_ONESHOT = 3'h0;
   localparam logic [2:0] MODE_REP0    = 3'h1;
   localparam logic [2:0] MODE_REP1    = 3'h2;
   localparam logic [2:0] MODE_SSWEEP  = 3'h4;
   localparam logic [2:0] MODE_RSWEEP  = 3'h5;

   localparam logic [1:0] TRG_SW  = 2'h0;
   localparam logic [1:0] TRG_TMR = 2'h2;
   localparam logic [1:0] TRG_EXT = 2'h3;

   localparam logic [3:0] AN_REF = 4'hc;

   localparam logic [2:0] RST_MODE  = 3'h0;
   localparam logic [1:0] RST_TRIG  = 2'h0;
   localparam logic [5:0] RST_INSEL = 6'h00;

   typedef struct packed {
      logic [1:0] group;
      logic       sweep4;
      logic [2:0] chan;
   } insel_s;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } conv_res_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARM  = 3'b010,
      ST_CONV = 3'b100
   } seq_state_e;

endpackage

// ==== adc_sar_engine.sv ====
`timescale 1ns/1ps
module adc_sar_engine #(
   parameter int unsigned CYCLES = adc_seq_pkg::CONV_CYCLES
) (
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_b,
   // Control
   input  wire logic                  i_start,
   input  wire logic                  i_abort,
   input  wire logic                  i_res10,
   // Sampled input
   input  wire logic [9:0]            i_ain,
   // Result
   output adc_seq_pkg::conv_res_s     o_res
);
   import adc_seq_pkg::*;

   logic [7:0] cnt_q, cnt_d;
   logic       busy_q, busy_d;
   conv_res_s  res_q, res_d;

   always_comb begin
      cnt_d  = cnt_q;
      busy_d = busy_q;
      res_d  = res_q;
      res_d.done = 1'b0;
      if (i_abort) begin
         busy_d = 1'b0;
      end else if (i_start) begin
         busy_d = 1'b1;
         cnt_d  = 8'(CYCLES - 1);
      end else if (busy_q) begin
         if (cnt_q == 8'h00) begin
            busy_d     = 1'b0;
            res_d.done = 1'b1;
            // Low resolution keeps the upper eight bits
            res_d.data = i_res10 ? i_ain : {2'h0, i_ain[9:2]};
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cnt_q  <= 8'h00;
         busy_q <= 1'b0;
         res_q  <= '0;
      end else begin
         cnt_q  <= cnt_d;
         busy_q <= busy_d;
         res_q  <= res_d;
      end
   end

   assign o_res = res_q;

endmodule // adc_sar_engine

// ==== adc_sensor_model.sv ====
`timescale 1ns/1ps
module adc_sensor_model (
   // Selected input from the sequencer
   input  wire logic [3:0] i_chan_sel,
   // Sensor level as a digital code
   output logic      [9:0] o_ain
);
   // Distinct level per input, so a wrong slot shows up
   always_comb begin
      o_ain = 10'h0a5 + 10'(i_chan_sel) * 10'h031;
   end
endmodule // adc_sensor_model

// ==== adc_repeat_sweep_sequencer_bench.sv ====
`timescale 1ns/1ps
module adc_repeat_sweep_sequencer_bench;
   import adc_seq_pkg::*;
   logic        i_clk;
   logic        i_rst_b;
   logic        hsel;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hresp;
   logic [31:0] rdata;
   logic        cmp_flag;
   logic        ext_b;
   logic [9:0]  ain;
   logic [3:0]  chan;
   logic        ana_on;
   logic        ref_en;
   logic        irq;
   int          failures;
   int          samples_checked;
   int          irqs;
   int          cyc;
   int          n;

   adc_repeat_sweep_sequencer i_adc_repeat_sweep_sequencer (
      .i_clk(i_clk), .i_rst_b(i_rst_b), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
      .o_hresp(hresp), .o_hrdata(rdata), .i_cmp_flag(cmp_flag),
      .i_ext_trig_b(ext_b), .i_ain(ain), .o_chan_sel(chan),
      .o_analog_on(ana_on), .o_ref_en(ref_en), .o_irq(irq));

   adc_sensor_model i_adc_sensor_model (.i_chan_sel(chan), .o_ain(ain));

   initial begin
      i_clk = 1'b0;
      // One never-stopped clock serves bus and converter alike
      forever #20 i_clk = ~i_clk;
   end

   always @(posedge i_clk) begin
      if (irq === 1'b1) irqs <= irqs + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         test_done();
      end
   end

   function automatic logic [31:0] lvl(input int c);
      return 32'(10'h0a5 + 10'(c) * 10'h031);
   endfunction

   function automatic logic [31:0] md(input logic [2:0] m,
                                      input logic [1:0] t);
      return 32'(m) | (32'(t) << MODE_TRIG_LSB);
   endfunction

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One single AHB-Lite transfer, address phase then data phase
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge i_clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      hsize  <= 3'h2;
      do @(posedge i_clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_clk); while (hready !== 1'b1);
      q = rdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e,
                     input string nm);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, e, q);
      chk("hresp", 32'h0, 32'(hresp));
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge i_clk);
   endtask

   task automatic wait_irq(input int k);
      int t;
      t = irqs + k;
      for (int i = 0; i < 1500 && irqs < t; i++) @(posedge i_clk);
      chk("irq seen", 32'h1, 32'(irqs >= t));
   endtask

   task automatic test_done;
      $display("checked %0d failed %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      i_rst_b = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h0;
      hwdata = 32'h0;
      cmp_flag = 1'b0;
      ext_b = 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rc(OFS_CTRL0, 32'h0, "ctrl0 reset");
      rc(OFS_MODE, 32'h0, "mode reset");
      rc(8'h40, 32'h0, "unmapped");
      chk("analog on", 32'h0, 32'(ana_on));
      chk("ref off", 32'h0, 32'(ref_en));
      $display("test reset done");
      // Repeat sweep over inputs 0-1, then 8-9, ended by abort
      for (int g = 0; g < 2; g++) begin
         wr(OFS_CTRL1, 32'h5);
         wr(OFS_MODE, md(MODE_RSWEEP, TRG_SW));
         wr(OFS_INSEL, 32'(g << 4));
         wr(OFS_CTRL0, 32'h1);
         wait_irq(2);
         rc(OFS_CTRL0, 32'h3, "still running");
         rc(OFS_RESULT, lvl(8 * g), "sweep slot 0");
         rc(OFS_RESULT + 8'h4, lvl(8 * g + 1), "sweep slot 1");
         idle(20);
         n = irqs;
         wr(OFS_CTRL0, 32'h0);
         idle(100);
         chk("abort irq", 32'(n), 32'(irqs));
         rc(OFS_CTRL0, 32'h0, "stopped");
      end
      $display("test repeat sweep done");
      // Single sweep of four pins, pin trigger, 8-bit results
      wr(OFS_CTRL1, 32'h1);
      wr(OFS_MODE, md(MODE_SSWEEP, TRG_EXT));
      wr(OFS_INSEL, 32'h18);
      wr(OFS_CTRL0, 32'h1);
      idle(60);
      rc(OFS_CTRL0, 32'h1, "armed by pin");
      ext_b <= 1'b0;
      idle(3);
      ext_b <= 1'b1;
      wait_irq(1);
      rc(OFS_CTRL0, 32'h0, "sweep end");
      for (int i = 0; i < 4; i++)
         rc(OFS_RESULT + 8'(4 * i), lvl(8 + i) >> 2, "8-bit slot");
      wr(OFS_RESULT, 32'h3ff);
      rc(OFS_RESULT, lvl(8) >> 2, "slot write");
      $display("test single sweep done");
      // Repeat mode 0 on input 3, timer trigger
      wr(OFS_CTRL1, 32'h5);
      wr(OFS_MODE, md(MODE_REP0, TRG_TMR));
      wr(OFS_INSEL, 32'h3);
      wr(OFS_CTRL0, 32'h1);
      idle(60);
      rc(OFS_CTRL0, 32'h1, "armed by timer");
      n = irqs;
      cmp_flag <= 1'b1;
      idle(200);
      rc(OFS_CTRL0, 32'h3, "repeating");
      chk("no irq", 32'(n), 32'(irqs));
      rc(OFS_RESULT + 8'hc, lvl(3), "slot 3");
      chk("chan sel", 32'h3, 32'(chan));
      wr(OFS_CTRL0, 32'h0);
      cmp_flag <= 1'b0;
      $display("test repeat 0 done");
      // Repeat mode 1 on the internal reference
      wr(OFS_CTRL1, 32'h7);
      wr(OFS_REFCTL, 32'h1);
      wr(OFS_MODE, md(MODE_REP1, TRG_SW));
      wr(OFS_INSEL, 32'h0);
      idle(1);
      chk("ref en", 32'h1, 32'(ref_en));
      chk("analog enabled", 32'h1, 32'(ana_on));
      wr(OFS_CTRL0, 32'h1);
      wait_irq(1);
      chk("ref chan", 32'(AN_REF), 32'(chan));
      for (int i = 0; i < 8; i++)
         rc(OFS_RESULT + 8'(4 * i), lvl(12), "ring slot");
      wait_irq(1);
      wr(OFS_CTRL0, 32'h0);
      $display("test repeat 1 done");
      // One-shot on input 5, software trigger, ends by itself
      wr(OFS_CTRL1, 32'h5);
      wr(OFS_MODE, md(MODE_ONESHOT, TRG_SW));
      wr(OFS_INSEL, 32'h5);
      wr(OFS_CTRL0, 32'h1);
      wait_irq(1);
      rc(OFS_CTRL0, 32'h0, "one-shot end");
      rc(OFS_RESULT + 8'h14, lvl(5), "one-shot slot");
      wr(OFS_CTRL1, 32'h0);
      idle(1);
      chk("analog off", 32'h0, 32'(ana_on));
      $display("test one-shot done");
      test_done();
   end
endmodule // adc_repeat_sweep_sequencer_bench
